// >>> rtl/uart_ir_pkg.sv
package uart_ir_pkg;

  // ----------------------------------------
  // register map (word index, byte address = 4 * index)
  // ----------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [9:0] IDX_DATA = 10'h0200;
  localparam logic [9:0] IDX_MODE = 10'h0201;
  localparam logic [9:0] IDX_CTRL = 10'h0202;
  localparam logic [9:0] IDX_BAUD = 10'h0203;
  localparam logic [9:0] IDX_IR = 10'h0207;

  // ----------------------------------------
  // serial_mode_reg fields
  // ----------------------------------------
  localparam int MODE_TB8 = 7;
  localparam int MODE_RXE = 5;
  localparam int MODE_WU = 4;
  localparam int MODE_FM_LO = 2;
  localparam int MODE_CS_LO = 0;
  localparam logic [1:0] FM_7BIT = 2'h1;
  localparam logic [1:0] FM_8BIT = 2'h2;
  localparam logic [1:0] FM_9BIT = 2'h3;

  // ----------------------------------------
  // serial_ctrl_reg fields
  // ----------------------------------------
  localparam int CTRL_RB8 = 7;
  localparam int CTRL_EVEN = 6;
  localparam int CTRL_PE = 5;

  // ----------------------------------------
  // infrared_ctrl fields
  // ----------------------------------------
  localparam int IR_TX_PULSE_WIDTH_SEL = 7;
  localparam int IR_RX_PULSE_POLARITY_SEL = 6;
  localparam int IR_IR_TX_ENABLE = 5;
  localparam int IR_IR_RX_ENABLE = 4;
  localparam int IR_WD_LO = 0;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] IR_RST = 8'h00;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int DEF_BAUD_BPS = 9600;
  localparam int OVS = 16;
  localparam logic [15:0] BAUD_DIV_RST = 16'(CLK_HZ / (DEF_BAUD_BPS * OVS) - 1);
  localparam logic [3:0] SAMPLE_PH = 4'h7;
  localparam logic [3:0] LAST_PH = 4'hF;
  localparam logic [3:0] PW_3_16 = 4'h3;
  localparam logic [3:0] PW_1_16 = 4'h1;
  localparam logic [4:0] DEMOD_HOLD = 5'h10;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;

endpackage

// >>> rtl/ir_modem.sv
module ir_modem (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // from the serial channel
  input wire logic ser_tx_i,
  input wire logic [3:0] tx_phase_i,
  input wire logic tick_i,
  // infrared control
  input wire logic [7:0] ir_ctrl_i,
  // pins and channel input
  output logic tx_line_o,
  input wire logic rx_line_i,
  output logic ser_rx_o
);

  typedef struct packed {
    logic tx_line;
    logic ser_rx;
    logic [3:0] wcnt;
    logic [4:0] hold;
  } ir_st_t;

  ir_st_t st_ff;
  ir_st_t nxt_st;
  logic active;
  logic [3:0] pw;
  logic [3:0] min_w;

  assign pw = ir_ctrl_i[uart_ir_pkg::IR_TX_PULSE_WIDTH_SEL] ? uart_ir_pkg::PW_1_16
                                                : uart_ir_pkg::PW_3_16;
  // a low pulse counts when polarity select is 1
  assign active = rx_line_i ^ ir_ctrl_i[uart_ir_pkg::IR_RX_PULSE_POLARITY_SEL];
  assign min_w = ir_ctrl_i[uart_ir_pkg::IR_WD_LO +: 4];

  always_comb begin
    nxt_st = st_ff;
    // ----------------------------------------
    // modulator
    // ----------------------------------------
    if (ir_ctrl_i[uart_ir_pkg::IR_IR_TX_ENABLE]) begin
      // zero bit -> short high pulse at bit start, one bit -> pin low
      nxt_st.tx_line = ~ser_tx_i & (tx_phase_i < pw);
    end else begin
      nxt_st.tx_line = ser_tx_i;
    end
    // ----------------------------------------
    // demodulator
    // ----------------------------------------
    if (tick_i && st_ff.hold != 5'h00) begin
      nxt_st.hold = st_ff.hold - 5'h01;
    end
    if (!active) begin
      nxt_st.wcnt = 4'h0;
    end else if (st_ff.wcnt != 4'hF) begin
      nxt_st.wcnt = st_ff.wcnt + 4'h1;
    end
    // width reached after (min_w + 1) reference clock cycles; fires once per pulse, or every active cycle once wcnt saturates if min_w is 15
    if (active && st_ff.wcnt == min_w) begin
      nxt_st.hold = uart_ir_pkg::DEMOD_HOLD;
    end
    if (ir_ctrl_i[uart_ir_pkg::IR_IR_RX_ENABLE]) begin
      // stretch a valid pulse into a zero lasting one bit time
      nxt_st.ser_rx = (nxt_st.hold == 5'h00);
    end else begin
      nxt_st.ser_rx = rx_line_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= '{tx_line: 1'b1, ser_rx: 1'b1, wcnt: 4'h0, hold: 5'h00};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tx_line_o = st_ff.tx_line;
  assign ser_rx_o = st_ff.ser_rx;

endmodule

// >>> rtl/uart_frames_ir_modem.sv
// Functional notes
// - frame mode 01 sends and receives seven data bits.
// - 7/8-bit modes add parity only if enabled; even or odd per select.
// - frame mode 10 uses eight data bits.
// - frame mode 11 uses nine data bits and never adds parity.
// - nine-bit mode sends tx_ninth_bit and stores received ninth bit in rx_ninth_bit.
// - nine-bit mode with wake-up: receive event only when ninth bit is 1.
// - master first sends slave select code with ninth bit set.
// - master then sends data with ninth bit clear; idle slaves see nothing.
// - infrared zero is a short high pulse, one is a low bit.
// - pulse width select 0 gives 3/16 bit, 1 gives 1/16 bit.
// - receiver gives 0 on a pulse of at least the set width, else 1.
// - polarity select 0 takes high pulses, 1 takes low pulses.
// - infrared transmit and receive paths each have their own enable bit.
// - minimum receive width is field value plus one prescaler periods; 0000, 1111 banned (code counts reference clock cycles).
//
// Added by the designer: the APB register port.
module uart_frames_ir_modem (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [uart_ir_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // serial pins
  output logic tx_line_o,
  input wire logic rx_line_i,
  // frame events
  output logic tx_done_irq_o,
  output logic rx_done_irq_o
);

  typedef struct packed {
    logic [7:0] mode;
    logic pe;
    logic even;
    logic rb8;
    logic perr;
    logic ferr;
    logic oerr;
    logic rx_rdy;
    logic [7:0] ir;
    logic [15:0] baud;
    logic [15:0] bcnt;
    uart_ir_pkg::tx_state_t tx_st;
    logic [3:0] tx_ph;
    logic [3:0] tx_bit;
    logic [8:0] tx_sh;
    logic tx_par;
    uart_ir_pkg::rx_state_t rx_st;
    logic [3:0] rx_ph;
    logic [3:0] rx_bit;
    logic [8:0] rx_sh;
    logic rx_par;
    logic rx_pbad;
    logic [7:0] rx_buf;
    logic [31:0] prdata;
    logic tx_irq;
    logic rx_irq;
  } uart_st_t;

  uart_st_t st_ff;
  uart_st_t nxt_st;

  logic tick;
  logic acc;
  logic wr;
  logic rd;
  logic setup;
  logic [9:0] idx;
  logic idx_ok;
  logic [1:0] fm;
  logic [3:0] nbits;
  logic par_on;
  logic [7:0] dmask;
  logic txd;
  logic rxd;
  logic tx_busy;
  logic [8:0] rx_al;
  logic [7:0] ctrl_rd;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  assign idx = paddr_i[11:2];
  assign idx_ok = (idx == uart_ir_pkg::IDX_DATA) || (idx == uart_ir_pkg::IDX_MODE) ||
                  (idx == uart_ir_pkg::IDX_CTRL) || (idx == uart_ir_pkg::IDX_BAUD) ||
                  (idx == uart_ir_pkg::IDX_IR);
  assign setup = psel_i & ~penable_i;
  assign acc = psel_i & penable_i;
  assign wr = acc & pwrite_i & idx_ok;
  assign rd = acc & ~pwrite_i & idx_ok;
  assign pready_o = acc;
  assign pslverr_o = acc & ~idx_ok;
  assign prdata_o = st_ff.prdata;

  // ----------------------------------------
  // frame format
  // ----------------------------------------
  assign fm = st_ff.mode[uart_ir_pkg::MODE_FM_LO +: 2];

  always_comb begin
    case (fm)
      uart_ir_pkg::FM_7BIT: nbits = 4'd7;
      uart_ir_pkg::FM_9BIT: nbits = 4'd9;
      uart_ir_pkg::FM_8BIT: nbits = 4'd8;
      default: nbits = 4'd8;
    endcase
  end

  // nine-bit mode never carries parity
  assign par_on = st_ff.pe && (fm != uart_ir_pkg::FM_9BIT);
  assign dmask = (fm == uart_ir_pkg::FM_7BIT) ? 8'h7F : 8'hFF;
  // >= so that lowering the divider mid-count cannot stall the tick for a full wrap
  assign tick = (st_ff.bcnt >= st_ff.baud);
  assign tx_busy = (st_ff.tx_st != uart_ir_pkg::TX_IDLE);
  // received bits arrive at the top; drop the unused low positions
  assign rx_al = st_ff.rx_sh >> (4'd9 - nbits);
  assign ctrl_rd = {st_ff.rb8, st_ff.even, st_ff.pe, st_ff.perr,
                    st_ff.ferr, st_ff.oerr, st_ff.rx_rdy, tx_busy};

  // line level during each frame section
  always_comb begin
    case (st_ff.tx_st)
      uart_ir_pkg::TX_START: txd = 1'b0;
      uart_ir_pkg::TX_DATA: txd = st_ff.tx_sh[0];
      uart_ir_pkg::TX_PAR: txd = st_ff.tx_par;
      default: txd = 1'b1;
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tx_irq = 1'b0;
    nxt_st.rx_irq = 1'b0;
    nxt_st.bcnt = tick ? 16'h0000 : st_ff.bcnt + 16'h0001;

    // read data is captured in the setup cycle so it leaves a flop
    if (setup) begin
      case (idx)
        uart_ir_pkg::IDX_DATA: nxt_st.prdata = {24'h00_0000, st_ff.rx_buf};
        uart_ir_pkg::IDX_MODE: nxt_st.prdata = {24'h00_0000, st_ff.mode};
        uart_ir_pkg::IDX_CTRL: nxt_st.prdata = {24'h00_0000, ctrl_rd};
        uart_ir_pkg::IDX_BAUD: nxt_st.prdata = {16'h0000, st_ff.baud};
        uart_ir_pkg::IDX_IR: nxt_st.prdata = {24'h00_0000, st_ff.ir};
        default: nxt_st.prdata = 32'h0000_0000;
      endcase
    end

    // register writes and read side effects
    if (wr) begin
      case (idx)
        uart_ir_pkg::IDX_MODE: nxt_st.mode = pwdata_i[7:0];
        uart_ir_pkg::IDX_CTRL: begin
          nxt_st.even = pwdata_i[uart_ir_pkg::CTRL_EVEN];
          nxt_st.pe = pwdata_i[uart_ir_pkg::CTRL_PE];
        end
        uart_ir_pkg::IDX_BAUD: nxt_st.baud = pwdata_i[15:0];
        uart_ir_pkg::IDX_IR: nxt_st.ir = pwdata_i[7:0];
        default: ;
      endcase
    end
    if (rd && idx == uart_ir_pkg::IDX_DATA) begin
      nxt_st.rx_rdy = 1'b0;
    end
    if (rd && idx == uart_ir_pkg::IDX_CTRL) begin
      nxt_st.perr = 1'b0;
      nxt_st.ferr = 1'b0;
      nxt_st.oerr = 1'b0;
    end

    // ----------------------------------------
    // transmitter
    // ----------------------------------------
    case (st_ff.tx_st)
      uart_ir_pkg::TX_IDLE: begin
        // a data write while busy is dropped: there is no holding buffer
        if (wr && idx == uart_ir_pkg::IDX_DATA) begin
          // ninth bit rides above the data byte
          nxt_st.tx_sh = {st_ff.mode[uart_ir_pkg::MODE_TB8], pwdata_i[7:0]};
          nxt_st.tx_par = ^(pwdata_i[7:0] & dmask) ^ ~st_ff.even;
          nxt_st.tx_ph = 4'h0;
          nxt_st.tx_bit = 4'h0;
          nxt_st.tx_st = uart_ir_pkg::TX_START;
        end
      end
      uart_ir_pkg::TX_START: begin
        if (tick) begin
          nxt_st.tx_ph = st_ff.tx_ph + 4'h1;
          if (st_ff.tx_ph == uart_ir_pkg::LAST_PH) begin
            nxt_st.tx_st = uart_ir_pkg::TX_DATA;
          end
        end
      end
      uart_ir_pkg::TX_DATA: begin
        if (tick) begin
          nxt_st.tx_ph = st_ff.tx_ph + 4'h1;
          if (st_ff.tx_ph == uart_ir_pkg::LAST_PH) begin
            nxt_st.tx_sh = {1'b0, st_ff.tx_sh[8:1]};
            nxt_st.tx_bit = st_ff.tx_bit + 4'h1;
            if (st_ff.tx_bit == nbits - 4'd1) begin
              nxt_st.tx_st = par_on ? uart_ir_pkg::TX_PAR : uart_ir_pkg::TX_STOP;
            end
          end
        end
      end
      uart_ir_pkg::TX_PAR: begin
        if (tick) begin
          nxt_st.tx_ph = st_ff.tx_ph + 4'h1;
          if (st_ff.tx_ph == uart_ir_pkg::LAST_PH) begin
            nxt_st.tx_st = uart_ir_pkg::TX_STOP;
          end
        end
      end
      uart_ir_pkg::TX_STOP: begin
        if (tick) begin
          nxt_st.tx_ph = st_ff.tx_ph + 4'h1;
          if (st_ff.tx_ph == uart_ir_pkg::LAST_PH) begin
            nxt_st.tx_st = uart_ir_pkg::TX_IDLE;
            nxt_st.tx_irq = 1'b1;
          end
        end
      end
      default: nxt_st.tx_st = uart_ir_pkg::TX_IDLE;
    endcase

    // ----------------------------------------
    // receiver, sampling at mid bit
    // ----------------------------------------
    if (st_ff.rx_st != uart_ir_pkg::RX_IDLE && tick) begin
      nxt_st.rx_ph = st_ff.rx_ph + 4'h1;
    end
    case (st_ff.rx_st)
      uart_ir_pkg::RX_IDLE: begin
        if (st_ff.mode[uart_ir_pkg::MODE_RXE] && !rxd) begin
          nxt_st.rx_ph = 4'h0;
          nxt_st.rx_bit = 4'h0;
          nxt_st.rx_par = 1'b0;
          nxt_st.rx_pbad = 1'b0;
          nxt_st.rx_st = uart_ir_pkg::RX_START;
        end
      end
      uart_ir_pkg::RX_START: begin
        if (tick && st_ff.rx_ph == uart_ir_pkg::SAMPLE_PH && rxd) begin
          // glitch, not a start bit
          nxt_st.rx_st = uart_ir_pkg::RX_IDLE;
        end else if (tick && st_ff.rx_ph == uart_ir_pkg::LAST_PH) begin
          nxt_st.rx_st = uart_ir_pkg::RX_DATA;
        end
      end
      uart_ir_pkg::RX_DATA: begin
        if (tick && st_ff.rx_ph == uart_ir_pkg::SAMPLE_PH) begin
          nxt_st.rx_sh = {rxd, st_ff.rx_sh[8:1]};
          nxt_st.rx_par = st_ff.rx_par ^ rxd;
        end
        if (tick && st_ff.rx_ph == uart_ir_pkg::LAST_PH) begin
          nxt_st.rx_bit = st_ff.rx_bit + 4'h1;
          if (st_ff.rx_bit == nbits - 4'd1) begin
            nxt_st.rx_st = par_on ? uart_ir_pkg::RX_PAR : uart_ir_pkg::RX_STOP;
          end
        end
      end
      uart_ir_pkg::RX_PAR: begin
        if (tick && st_ff.rx_ph == uart_ir_pkg::SAMPLE_PH) begin
          nxt_st.rx_pbad = (rxd != (st_ff.rx_par ^ ~st_ff.even));
        end
        if (tick && st_ff.rx_ph == uart_ir_pkg::LAST_PH) begin
          nxt_st.rx_st = uart_ir_pkg::RX_STOP;
        end
      end
      uart_ir_pkg::RX_STOP: begin
        // finish at mid stop bit so a following start edge is not missed
        if (tick && st_ff.rx_ph == uart_ir_pkg::SAMPLE_PH) begin
          nxt_st.rx_st = uart_ir_pkg::RX_IDLE;
          // wake-up filter discards frames whose ninth bit is clear
          if (!(fm == uart_ir_pkg::FM_9BIT && st_ff.mode[uart_ir_pkg::MODE_WU] &&
                !rx_al[8])) begin
            nxt_st.rx_buf = rx_al[7:0];
            if (fm == uart_ir_pkg::FM_9BIT) begin
              nxt_st.rb8 = rx_al[8];
            end
            // set beats a same-cycle clear by read
            nxt_st.oerr = nxt_st.oerr | (st_ff.rx_rdy & nxt_st.rx_rdy);
            nxt_st.ferr = nxt_st.ferr | ~rxd;
            nxt_st.perr = nxt_st.perr | st_ff.rx_pbad;
            nxt_st.rx_rdy = 1'b1;
            nxt_st.rx_irq = 1'b1;
          end
        end
      end
      default: nxt_st.rx_st = uart_ir_pkg::RX_IDLE;
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff <= '{mode: uart_ir_pkg::MODE_RST, ir: uart_ir_pkg::IR_RST,
                 baud: uart_ir_pkg::BAUD_DIV_RST, tx_st: uart_ir_pkg::TX_IDLE,
                 rx_st: uart_ir_pkg::RX_IDLE, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tx_done_irq_o = st_ff.tx_irq;
  assign rx_done_irq_o = st_ff.rx_irq;

  // ----------------------------------------
  // infrared modem between channel and pins
  // ----------------------------------------
  ir_modem u_ir_modem (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .ser_tx_i(txd),
    .tx_phase_i(st_ff.tx_ph),
    .tick_i(tick),
    .ir_ctrl_i(st_ff.ir),
    .tx_line_o(tx_line_o),
    .rx_line_i(rx_line_i),
    .ser_rx_o(rxd)
  );

endmodule

// >>> tb/uart_frames_ir_modem_monitor.sv
module uart_frames_ir_modem_monitor (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [uart_ir_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // serial pins and events
  input wire logic tx_line_o,
  input wire logic rx_line_i,
  input wire logic tx_done_irq_o,
  input wire logic rx_done_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ir_ff;
  logic acc;
  logic hit;
  logic rd_ir;
  assign acc = psel_i & penable_i;
  assign rd_ir = acc & ~pwrite_i & (paddr_i[11:2] == uart_ir_pkg::IDX_IR);
  assign hit = paddr_i[11:2] inside {uart_ir_pkg::IDX_DATA, uart_ir_pkg::IDX_MODE,
    uart_ir_pkg::IDX_CTRL, uart_ir_pkg::IDX_BAUD, uart_ir_pkg::IDX_IR};
  // -----------------------------
  // infrared control shadow
  // -----------------------------
  // updated at the access edge only, as the slave does
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ir_ff <= uart_ir_pkg::IR_RST;
    end else if (acc && pwrite_i && paddr_i[11:2] == uart_ir_pkg::IDX_IR) begin
      ir_ff <= pwdata_i[7:0];
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // -----------------------------
  // properties
  // -----------------------------
  a_ready_access: assert property (pready_o == acc) else $error("pready not zero wait");
  a_err_unmapped: assert property (acc |-> pslverr_o == !hit) else $error("pslverr wrong");
  a_rd_unmapped: assert property (acc && !pwrite_i && !hit |-> prdata_o == '0)
    else $error("unmapped read not zero");
  a_ir_readback: assert property (rd_ir |-> prdata_o == {24'h00_0000, ir_ff})
    else $error("infrared control readback wrong");
  a_tx_pulse_once: assert property (tx_done_irq_o |=> !tx_done_irq_o)
    else $error("tx done longer than one cycle");
  a_rx_pulse_once: assert property (rx_done_irq_o |=> !rx_done_irq_o)
    else $error("rx done longer than one cycle");
  a_stop_high: assert property (
    tx_done_irq_o && !ir_ff[5] |-> tx_line_o && $past(tx_line_o, 8))
    else $error("stop bit not high");
  a_ir_stop_low: assert property (
    tx_done_irq_o && ir_ff[5] |-> !tx_line_o && !$past(tx_line_o, 8))
    else $error("infrared one not low");
  a_start_len: assert property ($fell(tx_line_o) && !ir_ff[5] |-> !tx_line_o [*8])
    else $error("low bit too short");
  c_ir_tx: cover property (tx_done_irq_o && ir_ff[5]);
  c_ir_rx: cover property (rx_done_irq_o && ir_ff[4]);
  c_err: cover property (acc && pslverr_o);
endmodule

bind uart_frames_ir_modem uart_frames_ir_modem_monitor u_mon (.ref_clk_i, .rst_i, .psel_i,
  .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .tx_line_o,
  .rx_line_i, .tx_done_irq_o, .rx_done_irq_o);

// >>> tb/uart_remote_peer.sv
module uart_remote_peer #(parameter int BIT_CLKS = 16) (
  // clock
  input wire logic ref_clk_i,
  // serial lines
  input wire logic tx_line_i,
  output logic rx_line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rx_line_o = 1'b1;
  // a zero is a short pulse of the active level in infrared mode
  task automatic drive_bit(input logic b, input logic ir, input logic low, input int wid);
    for (int i = 0; i < BIT_CLKS; i++) begin
      @(posedge ref_clk_i);
      rx_line_o <= ir ? (low ^ (!b && i < wid)) : b;
    end
  endtask
  // idle bit first so a polarity change settles before the start bit
  task automatic send(input logic [8:0] bits, input int n, input logic ir, input logic low,
                      input int wid);
    drive_bit(1'b1, ir, low, wid);
    drive_bit(1'b0, ir, low, wid);
    for (int i = 0; i < n; i++) drive_bit(bits[i], ir, low, wid);
    drive_bit(1'b1, ir, low, wid);
  endtask
  task automatic grab(input int n, output logic [11:0] w);
    w = '0;
    for (int i = 0; i < 2000 && tx_line_i !== 1'b0; i++) @(posedge ref_clk_i);
    repeat (BIT_CLKS / 2) @(posedge ref_clk_i);
    for (int i = 0; i < n + 2; i++) begin
      w[i] = tx_line_i;
      repeat (BIT_CLKS) @(posedge ref_clk_i);
    end
  endtask
endmodule

// >>> tb/uart_frames_ir_modem_tb_top.sv
module uart_frames_ir_modem_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, tx_line, rx_line, tx_irq, rx_irq;
  logic err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int tx_cnt = 0;
  int rx_cnt = 0;
  int hi_cnt = 0;

  uart_frames_ir_modem u_uart_frames_ir_modem (.ref_clk_i(clk), .rst_i(rst), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .tx_line_o(tx_line),
    .rx_line_i(rx_line), .tx_done_irq_o(tx_irq), .rx_done_irq_o(rx_irq));
  uart_remote_peer #(.BIT_CLKS(16)) u_uart_remote_peer (.ref_clk_i(clk), .tx_line_i(tx_line),
    .rx_line_o(rx_line));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (tx_irq === 1'b1) tx_cnt++;
    if (rx_irq === 1'b1) rx_cnt++;
    if (tx_line === 1'b1) hi_cnt++;
    if (cycles == 60000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic test_done();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, want);
    end
  endtask
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // -----------------------------
  // frame model
  // -----------------------------
  function automatic logic [8:0] fbits(input logic [8:0] d, input int fm, input logic pe,
                                       input logic ev);
    logic [8:0] m;
    m = d & 9'((1 << (fm + 6)) - 1);
    if (pe && fm != 3) m[fm + 6] = ^m ^ !ev;
    return m;
  endfunction
  function automatic int flen(input int fm, input logic pe);
    return fm + 6 + int'(pe && fm != 3);
  endfunction
  function automatic logic [31:0] mode_w(input logic tb8, input logic wu, input int fm);
    return 32'({tb8, 2'b01, wu, 2'(fm), 2'b01});
  endfunction
  task automatic rx_one(input logic [8:0] d, input int fm, input logic pe, input logic wu,
                        input logic ir, input logic low, input int wid, input int want);
    int n0;
    logic [7:0] m;
    m = 8'((1 << (fm + 6)) - 1);
    apb(1'b1, uart_ir_pkg::IDX_MODE, mode_w(1'b0, wu, fm));
    n0 = rx_cnt;
    u_uart_remote_peer.send(fbits(d, fm, pe, 1'b0), flen(fm, pe), ir, low, wid);
    check(rx_cnt - n0, want);
    if (want == 1) begin
      apb(1'b0, uart_ir_pkg::IDX_CTRL, '0);
      if (fm == 3) check(32'(rd[7]), 32'(d[8]));
      check(32'(rd[4:2]), '0);
      apb(1'b0, uart_ir_pkg::IDX_DATA, '0);
      check(32'(rd[7:0] & m), 32'(d[7:0] & m));
    end
  endtask
  // -----------------------------
  // main sequence
  // -----------------------------
  initial begin
    logic [8:0] d;
    logic [11:0] w;
    int n0;
    int h0;
    int rem;
    logic [31:0] exp_w;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    d = 9'($urandom(5850));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, uart_ir_pkg::IDX_IR, '0);
    check(rd, '0);
    apb(1'b0, uart_ir_pkg::IDX_MODE, '0);
    check(rd, '0);
    apb(1'b0, 10'h100, '0);
    check(rd, '0);
    check(32'(err), 32'h0000_0001);
    apb(1'b1, uart_ir_pkg::IDX_IR, 32'h0000_00c3);
    apb(1'b0, uart_ir_pkg::IDX_IR, '0);
    check(rd, 32'h0000_00c3);
    apb(1'b1, uart_ir_pkg::IDX_IR, '0);
    // fastest tick keeps frames short; whole divider only, no fractional divide
    apb(1'b1, uart_ir_pkg::IDX_BAUD, '0);
    for (int fm = 1; fm < 4; fm++) begin
      for (int k = 0; k < 4; k++) begin
        d = 9'($urandom);
        apb(1'b1, uart_ir_pkg::IDX_CTRL, 32'(k) << 5);
        apb(1'b1, uart_ir_pkg::IDX_MODE, mode_w(d[8], 1'b0, fm));
        n0 = tx_cnt;
        apb(1'b1, uart_ir_pkg::IDX_DATA, 32'(d[7:0]));
        u_uart_remote_peer.grab(flen(fm, k[0]), w);
        exp_w = 32'(fbits(d, fm, k[0], k[1])) << 1 | 32'h0000_0001 << (flen(fm, k[0]) + 1);
        check(32'(w), exp_w);
        for (int j = 0; j < 64 && tx_cnt == n0; j++) @(posedge clk);
        check(tx_cnt - n0, 1);
      end
    end
    for (int fm = 1; fm < 4; fm++) begin
      for (int k = 0; k < 2; k++) begin
        apb(1'b1, uart_ir_pkg::IDX_CTRL, 32'(k) << 5);
        rx_one(9'($urandom), fm, k[0], 1'b0, 1'b0, 1'b0, 0, 1);
      end
    end
    // filtered data, then select code, then data to the woken slave
    apb(1'b1, uart_ir_pkg::IDX_CTRL, '0);
    for (int t = 0; t < 3; t++) begin
      d = {t == 1, 8'($urandom)};
      rx_one(d, 3, 1'b0, t < 2, 1'b0, 1'b0, 0, int'(t > 0));
    end
    // enables go on only after the other fields are set
    for (int pw = 0; pw < 2; pw++) begin
      d = 9'($urandom);
      // narrow pulse only at low rate: divider 81 gives about 38.1 kbps
      apb(1'b1, uart_ir_pkg::IDX_BAUD, 32'(pw * 81));
      apb(1'b1, uart_ir_pkg::IDX_IR, 32'(pw) << 7 | 32'h0000_0003);
      apb(1'b1, uart_ir_pkg::IDX_IR, 32'(pw) << 7 | 32'h0000_0023);
      apb(1'b1, uart_ir_pkg::IDX_MODE, mode_w(1'b0, 1'b0, 2));
      n0 = tx_cnt;
      h0 = hi_cnt;
      apb(1'b1, uart_ir_pkg::IDX_DATA, 32'(d[7:0]));
      for (int j = 0; j < 16000 && tx_cnt == n0; j++) @(posedge clk);
      // zero data bits give whole pulses; the start bit may begin mid tick
      rem = hi_cnt - h0 - (8 - $countones(d[7:0])) * (pw ? 82 : 3);
      check(32'(rem >= (pw ? 1 : 3) && rem <= (pw ? 82 : 3)), 32'h0000_0001);
      apb(1'b1, uart_ir_pkg::IDX_IR, '0);
    end
    apb(1'b1, uart_ir_pkg::IDX_BAUD, '0);
    // receiver off while the line moves to the infrared idle level: no false start
    apb(1'b1, uart_ir_pkg::IDX_MODE, '0);
    for (int pol = 0; pol < 2; pol++) begin
      u_uart_remote_peer.drive_bit(1'b1, 1'b1, pol[0], 0);
      apb(1'b1, uart_ir_pkg::IDX_IR, 32'(pol) << 6 | 32'h0000_0003);
      apb(1'b1, uart_ir_pkg::IDX_IR, 32'(pol) << 6 | 32'h0000_0013);
      rx_one(9'($urandom), 2, 1'b0, 1'b0, 1'b1, pol[0], 4, 1);
      rx_one(9'($urandom), 2, 1'b0, 1'b0, 1'b1, pol[0], 3, 0);
      apb(1'b1, uart_ir_pkg::IDX_MODE, '0);
      apb(1'b1, uart_ir_pkg::IDX_IR, '0);
    end
    test_done();
  end
endmodule
